// ---- ubfc_pkg.sv ----
//==============================================================================
// Overview of operation
// (R1) Channels 2-7 break only on fetch address
// (R2) Address registers clear only on power-on reset
// (R3) Software keeps address bit 0 at zero
// (R4) Disable bit 13 suppresses interrupt requests
// (R5) Condition register reserved bits read zero
// (R6) Bus-cycle select: 00 off, 01 fetch bus
// (R7) Fetch select: 00 off, 01 instruction fetch
// (R8) Condition registers clear only on power-on reset
// (R9) Flag write one keeps, zero clears
// (R10) Clear one flag: write ones elsewhere
// (R11) Internal-bus flags set by channels 1, 0
// (R12) CPU-bus flag 8+n set by channel n
// (R13) Width field: 10 four, 11 eight cycles
// (R14) Timing bit: 0 before, 1 after execution
// (R15) Control register clears only on power-on reset
// (R16) Control reserved bits 31-26, 23-18 read zero
// (R17) Match: interrupt, flag and trigger pulse
// (R18) Disabled interrupt still gives trigger pulse
// (R19) Uncleared flag keeps interrupt request raised
// (R20) No break for overrun, unexecuted fetches
// (R21) Match needs both selects 01, address equal
// (R22) Trigger active low for programmed width
package ubfc_pkg;

   //===========================================================================
   // Geometry
   localparam int NUM_CH   = 6;
   localparam int FIRST_CH = 2;

   //===========================================================================
   // Register offsets (byte addresses on the register port)
   localparam logic [7:0] BAR_BASE   = 8'h20;
   localparam logic [7:0] BAR_STRIDE = 8'h10;
   localparam logic [7:0] COND_BASE   = 8'ha8;
   localparam logic [7:0] COND_STRIDE = 8'h04;
   localparam logic [7:0] CTRL_OFF    = 8'hc0;

   //===========================================================================
   // Field positions
   localparam int COND_IRQDIS_BIT   = 13;
   localparam int COND_BUSSEL_LSB   = 6;
   localparam int COND_FETCHSEL_LSB = 4;
   localparam int CTRL_IFLAG_LSB    = 24;
   localparam int CTRL_WIDTH_LSB    = 16;
   localparam int CTRL_CFLAG_LSB    = 8;
   localparam int CTRL_TIMING_LSB   = 0;

   //===========================================================================
   // Encodings and timing counts
   localparam logic [1:0] SEL_ON    = 2'h1;
   localparam logic [1:0] WIDTH_W4  = 2'h2;
   localparam logic [1:0] WIDTH_W8  = 2'h3;
   localparam logic [3:0] TRIG_LEN4 = 4'h4;
   localparam logic [3:0] TRIG_LEN8 = 4'h8;

   //===========================================================================
   // Reset values
   localparam logic [31:0] BAR_RST   = 32'h0000_0000;
   localparam logic [1:0]  SEL_RST   = 2'h0;
   localparam logic [7:0]  BYTE_RST  = 8'h00;
   localparam logic [3:0]  CNT_RST   = 4'h0;

   //===========================================================================
   // Carriers
   typedef struct packed {
      logic        wrEn;
      logic        rdEn;
      logic [7:0]  addr;
      logic [31:0] wrData;
   } ubfc_reg_req_t;

   // Executed-instruction events; overrun fetches never appear here
   typedef struct packed {
      logic        startValid;
      logic [31:0] startAddr;
      logic        doneValid;
      logic [31:0] doneAddr;
   } ubfc_exec_t;

   typedef struct packed {
      logic [NUM_CH-1:0][31:0] bar;
      logic [NUM_CH-1:0]       irqDis;
      logic [NUM_CH-1:0][1:0]  busSel;
      logic [NUM_CH-1:0][1:0]  fetchSel;
      logic [1:0]              ibusFlag;
      logic [1:0]              trigWidth;
      logic [7:0]              cbusFlag;
      logic [7:0]              pcTiming;
      logic [3:0]              trigCnt;
      logic                    trigOut_b;
      logic                    breakIrq;
      logic [31:0]             rdData;
   } ubfc_state_t;

   localparam ubfc_state_t ST_RST = '{
      bar:       {NUM_CH{BAR_RST}},
      irqDis:    '0,
      busSel:    {NUM_CH{SEL_RST}},
      fetchSel:  {NUM_CH{SEL_RST}},
      ibusFlag:  SEL_RST,
      trigWidth: SEL_RST,
      cbusFlag:  BYTE_RST,
      pcTiming:  BYTE_RST,
      trigCnt:   CNT_RST,
      trigOut_b: 1'b1,
      breakIrq:  1'b0,
      rdData:    BAR_RST
   };

endpackage : ubfc_pkg

// ---- ubfc_fetch_break.sv ----
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
module ubfc_fetch_break (
   input  wire logic                   clk_sys,
   input  wire logic                   rst_b,
   input  wire ubfc_pkg::ubfc_reg_req_t regReq,
   output      logic [31:0]            regRdData,
   input  wire ubfc_pkg::ubfc_exec_t   execEvt,
   input  wire logic [1:0]             cbusMatch01,
   input  wire logic [1:0]             ibusMatch01,
   input  wire logic [1:0]             ch01IrqEn,
   output      logic                   breakIrq,
   output      logic                   breakTrigOut_b
);

   ubfc_pkg::ubfc_state_t st_q;
   ubfc_pkg::ubfc_state_t st_d;
   logic [7:0]            hitVec;
   logic                  wrCtrl;

   //===========================================================================
   // Helpers
   function automatic logic [7:0] barOff(input int ch);
      barOff = ubfc_pkg::BAR_BASE + 8'(ch) * ubfc_pkg::BAR_STRIDE;
   endfunction : barOff

   function automatic logic [7:0] condOff(input int ch);
      condOff = ubfc_pkg::COND_BASE + 8'(ch) * ubfc_pkg::COND_STRIDE;
   endfunction : condOff

   // Prohibited width codes fall back to the short pulse
   function automatic logic [3:0] trigLen(input logic [1:0] w);
      trigLen = (w == ubfc_pkg::WIDTH_W8) ? ubfc_pkg::TRIG_LEN8 : ubfc_pkg::TRIG_LEN4; // R13
   endfunction : trigLen

   // Before-execution breaks look at the start event, after-execution at the done event
   function automatic logic chanHit(input logic [1:0]  bsel,
                                    input logic [1:0]  fsel,
                                    input logic        after,
                                    input logic [31:0] bar,
                                    input ubfc_pkg::ubfc_exec_t ev);
      logic        v;
      logic [31:0] a;
      v = after ? ev.doneValid : ev.startValid; // R14 R20
      a = after ? ev.doneAddr : ev.startAddr;
      chanHit = v && (bsel == ubfc_pkg::SEL_ON) && (fsel == ubfc_pkg::SEL_ON) // R1 R6 R7 R21
                && (a == bar);
   endfunction : chanHit

   //===========================================================================
   // Next state
   always_comb begin
      st_d   = st_q;
      hitVec = {6'h00, cbusMatch01};
      wrCtrl = regReq.wrEn && (regReq.addr == ubfc_pkg::CTRL_OFF);
      for (int i = 0; i < ubfc_pkg::NUM_CH; i++) begin
         hitVec[i + ubfc_pkg::FIRST_CH] = chanHit(st_q.busSel[i], st_q.fetchSel[i],
            st_q.pcTiming[i + ubfc_pkg::FIRST_CH], st_q.bar[i], execEvt);
      end

      // Register writes
      for (int i = 0; i < ubfc_pkg::NUM_CH; i++) begin
         if (regReq.wrEn && regReq.addr == barOff(i)) begin
            st_d.bar[i] = regReq.wrData; // R2
         end
         if (regReq.wrEn && regReq.addr == condOff(i)) begin
            st_d.irqDis[i]   = regReq.wrData[ubfc_pkg::COND_IRQDIS_BIT]; // R4 R8
            st_d.busSel[i]   = regReq.wrData[ubfc_pkg::COND_BUSSEL_LSB +: 2];
            st_d.fetchSel[i] = regReq.wrData[ubfc_pkg::COND_FETCHSEL_LSB +: 2];
         end
      end
      if (wrCtrl) begin
         st_d.trigWidth = regReq.wrData[ubfc_pkg::CTRL_WIDTH_LSB +: 2]; // R15
         st_d.pcTiming  = regReq.wrData[ubfc_pkg::CTRL_TIMING_LSB +: 8];
         // A written one leaves its flag alone; only zeros clear
         st_d.cbusFlag = st_q.cbusFlag & regReq.wrData[ubfc_pkg::CTRL_CFLAG_LSB +: 8]; // R9 R10
         st_d.ibusFlag = st_q.ibusFlag & regReq.wrData[ubfc_pkg::CTRL_IFLAG_LSB +: 2];
      end
      // A match in the clearing cycle wins over the clear
      st_d.cbusFlag = st_d.cbusFlag | hitVec; // R12 R17
      st_d.ibusFlag = st_d.ibusFlag | ibusMatch01; // R11

      // Trigger pulse; a fresh match restarts the count
      if ((|hitVec) || (|ibusMatch01)) begin
         st_d.trigCnt = trigLen(st_q.trigWidth); // R13 R17 R18
      end else if (st_q.trigCnt != ubfc_pkg::CNT_RST) begin
         st_d.trigCnt = st_q.trigCnt - 4'h1;
      end
      st_d.trigOut_b = (st_d.trigCnt == ubfc_pkg::CNT_RST); // R22

      // Level request follows the flags, so an uncleared flag keeps it up
      st_d.breakIrq = (|(st_d.cbusFlag[7:2] & ~st_d.irqDis)) // R4 R18 R19
                   || (|((st_d.cbusFlag[1:0] | st_d.ibusFlag) & ch01IrqEn)); // R17

      // Read data stand only in the cycle after the strobe
      st_d.rdData = '0;
      if (regReq.rdEn) begin
         for (int i = 0; i < ubfc_pkg::NUM_CH; i++) begin
            if (regReq.addr == barOff(i)) begin
               st_d.rdData = st_q.bar[i];
            end
            if (regReq.addr == condOff(i)) begin
               st_d.rdData[ubfc_pkg::COND_IRQDIS_BIT]        = st_q.irqDis[i]; // R5
               st_d.rdData[ubfc_pkg::COND_BUSSEL_LSB +: 2]   = st_q.busSel[i];
               st_d.rdData[ubfc_pkg::COND_FETCHSEL_LSB +: 2] = st_q.fetchSel[i];
            end
         end
         if (regReq.addr == ubfc_pkg::CTRL_OFF) begin
            st_d.rdData[ubfc_pkg::CTRL_IFLAG_LSB +: 2]  = st_q.ibusFlag; // R16
            st_d.rdData[ubfc_pkg::CTRL_WIDTH_LSB +: 2]  = st_q.trigWidth;
            st_d.rdData[ubfc_pkg::CTRL_CFLAG_LSB +: 8]  = st_q.cbusFlag;
            st_d.rdData[ubfc_pkg::CTRL_TIMING_LSB +: 8] = st_q.pcTiming;
         end
      end
   end

   //===========================================================================
   // State register; only power-on reset reaches it
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= ubfc_pkg::ST_RST; // R2 R8 R15
      end else begin
         st_q <= st_d;
      end
   end

   assign regRdData      = st_q.rdData;
   assign breakIrq       = st_q.breakIrq;
   assign breakTrigOut_b = st_q.trigOut_b;

   //===========================================================================
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   a_flag_on_hit: assert property ((hitVec != 8'h00) |=> // R12
      ((st_q.cbusFlag & $past(hitVec)) == $past(hitVec)))
      else $error("match flag not set after a channel hit");

   a_flag_w1_keep: assert property ((wrCtrl && hitVec == 8'h00 && ibusMatch01 == 2'h0) |=> // R9
      (st_q.cbusFlag == ($past(st_q.cbusFlag) & $past(regReq.wrData[15:8]))))
      else $error("flag write did not keep ones and clear zeros");

   a_trig_four: assert property (((|hitVec) && st_q.trigWidth == 2'h2) |=> // R13
      (!breakTrigOut_b) [*4] ##1 (breakTrigOut_b || (|$past(hitVec)) || (|$past(ibusMatch01))))
      else $error("trigger pulse not four cycles");

   a_trig_eight: assert property (((|hitVec) && st_q.trigWidth == 2'h3) |=> // R22
      (!breakTrigOut_b) [*8])
      else $error("trigger pulse shorter than eight cycles");

   a_irq_raise: assert property ((|(hitVec[7:2] & ~st_q.irqDis)) |=> breakIrq) // R17
      else $error("no interrupt request after enabled hit");

   // A write may clear a flag or set a disable bit; an enable change may gate channels 0 and 1
   a_irq_held: assert property ((breakIrq && !regReq.wrEn // R19
      && ch01IrqEn == $past(ch01IrqEn)) |=> breakIrq)
      else $error("interrupt request dropped without a flag clear");

   a_irq_disabled: assert property ((st_q.irqDis == 6'h3f && ch01IrqEn == 2'h0 && !wrCtrl // R18
      && !(regReq.wrEn && regReq.addr >= 8'ha8 && regReq.addr <= 8'hbc)) |=> !breakIrq)
      else $error("interrupt request while all disabled");

   a_sel_off: assert property ((st_q.busSel[0] != 2'h1 || st_q.fetchSel[0] != 2'h1) // R21
      |-> !hitVec[2])
      else $error("channel 2 hit with comparison off");

   a_before_exec: assert property ((!st_q.pcTiming[2] && !execEvt.startValid) // R14
      |-> !hitVec[2])
      else $error("before-execution hit without start event");

   a_rdata_idle: assert property (!regReq.rdEn |=> (regRdData == 32'h0)) // R5
      else $error("read data present without a read strobe");

   a_cond_rsv: assert property ((regReq.rdEn && regReq.addr == 8'ha8) |=> // R5
      (regRdData[31:14] == 18'h0 && regRdData[12:8] == 5'h0 && regRdData[3:0] == 4'h0))
      else $error("condition register reserved bits not zero");

   a_ctrl_rsv: assert property ((regReq.rdEn && regReq.addr == 8'hc0) |=> // R16
      (regRdData[31:26] == 6'h0 && regRdData[23:18] == 6'h0))
      else $error("control register reserved bits not zero");

   c_trig_pulse: cover property ((|hitVec) ##1 !breakTrigOut_b);
   c_irq_up:     cover property ($rose(breakIrq));
   c_flag_clear: cover property (breakIrq ##1 !breakIrq);
   c_after_hit:  cover property (st_q.pcTiming[2] && hitVec[2]);

endmodule : ubfc_fetch_break

// ---- ubfc_cpu_model.sv ----
`timescale 1ns/1ps
module ubfc_cpu_model (
   input  wire logic                 clk_sys,
   output      ubfc_pkg::ubfc_exec_t execEvt
);
   //===========================================================================
   // Retire one instruction; overrun fetches are never reported
   task automatic retire(input logic [31:0] a, input logic dn);
      @(posedge clk_sys);
      execEvt <= '{!dn, a, dn, a};
      @(posedge clk_sys);
      // Idle address toggles so a stale match cannot pass unseen
      execEvt <= '{1'b0, ~a, 1'b0, ~a};
   endtask : retire

   initial execEvt = '0;
endmodule : ubfc_cpu_model

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
   logic                   clk_sys;
   logic                   rst_b;
   ubfc_pkg::ubfc_reg_req_t regReq;
   logic [31:0]            regRdData;
   ubfc_pkg::ubfc_exec_t   execEvt;
   logic [1:0]             cbusMatch01;
   logic [1:0]             ibusMatch01;
   logic [1:0]             ch01IrqEn;
   logic                   breakIrq;
   logic                   breakTrigOut_b;
   int                     failures;
   int                     num_checks;

   ubfc_fetch_break uut (.clk_sys(clk_sys), .rst_b(rst_b), .regReq(regReq),
      .regRdData(regRdData), .execEvt(execEvt), .cbusMatch01(cbusMatch01),
      .ibusMatch01(ibusMatch01), .ch01IrqEn(ch01IrqEn), .breakIrq(breakIrq),
      .breakTrigOut_b(breakTrigOut_b));
   ubfc_cpu_model uCpu (.clk_sys(clk_sys), .execEvt(execEvt));

   //===========================================================================
   // Tasks
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      regReq <= '{1'b1, 1'b0, a, d};
      @(posedge clk_sys);
      regReq <= '0;
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      regReq <= '{1'b0, 1'b1, a, 32'h0};
      @(posedge clk_sys);
      regReq <= '0;
      #1 chk("rdata", regRdData, e);
   endtask : rdc

   // Counts low trigger cycles over a window wider than the longest pulse
   task automatic hit(input logic [31:0] a, input logic dn, input logic [3:0] len,
                      input logic irq);
      logic [3:0] n;
      n = 4'h0;
      uCpu.retire(a, dn);
      #1 chk("irq", {31'h0, breakIrq}, {31'h0, irq});
      repeat (10) begin
         if (breakTrigOut_b === 1'b0) n = n + 4'h1;
         @(posedge clk_sys);
         #1;
      end
      chk("trigLen", {28'h0, n}, {28'h0, len});
   endtask : hit

   task automatic close_out;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : close_out

   //===========================================================================
   // Clock and watchdog
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   initial begin
      #100us;
      failures++;
      close_out();
   end

   //===========================================================================
   // Tests
   initial begin
      failures = 0;
      num_checks = 0;
      rst_b = 1'b0;
      regReq = '0;
      cbusMatch01 = 2'h0;
      ibusMatch01 = 2'h0;
      ch01IrqEn = 2'h3;
      repeat (4) @(posedge clk_sys);
      rst_b <= 1'b1;
      #1 chk("trigIdle", {31'h0, breakTrigOut_b}, 32'h1);
      rdc(8'hc0, 32'h0);
      rdc(8'h20, 32'h0);
      rdc(8'hbc, 32'h0);
      wr(8'h70, 32'hdeadbeee);
      rdc(8'h70, 32'hdeadbeee);
      wr(8'hbc, 32'h00002050);
      rdc(8'hbc, 32'h00002050);
      wr(8'h04, 32'hffffffff);
      rdc(8'h04, 32'h0);
      wr(8'hc0, 32'h0303ff00);
      rdc(8'hc0, 32'h00030000);
      wr(8'hc0, 32'h0302ff00);
      wr(8'h20, 32'h00001000);
      wr(8'ha8, 32'h00000050);
      hit(32'h1000, 1'b0, 4'h4, 1'b1);
      rdc(8'hc0, 32'h00020400);
      chk("irqHeld", {31'h0, breakIrq}, 32'h1);
      wr(8'hc0, 32'h0302fb00);
      rdc(8'hc0, 32'h00020000);
      chk("irqDrop", {31'h0, breakIrq}, 32'h0);
      hit(32'h1000, 1'b1, 4'h0, 1'b0);
      wr(8'ha8, 32'h00002050);
      hit(32'h1000, 1'b0, 4'h4, 1'b0);
      wr(8'hc0, 32'h0302fb00);
      wr(8'ha8, 32'h00000040);
      hit(32'h1000, 1'b0, 4'h0, 1'b0);
      wr(8'ha8, 32'h00000010);
      hit(32'h1000, 1'b0, 4'h0, 1'b0);
      wr(8'hc0, 32'h0303ff08);
      wr(8'h30, 32'h00002000);
      wr(8'hac, 32'h00000050);
      hit(32'h2000, 1'b0, 4'h0, 1'b0);
      hit(32'h2000, 1'b1, 4'h8, 1'b1);
      rdc(8'hc0, 32'h00030808);
      wr(8'hc0, 32'h0303f708);
      @(posedge clk_sys);
      ibusMatch01 <= 2'h2;
      @(posedge clk_sys);
      ibusMatch01 <= 2'h0;
      rdc(8'hc0, 32'h02030008);
      wr(8'hc0, 32'h0103ff08);
      @(posedge clk_sys);
      cbusMatch01 <= 2'h1;
      @(posedge clk_sys);
      cbusMatch01 <= 2'h0;
      rdc(8'hc0, 32'h00030108);
      // Gate every request source, then let a flag set with no request
      for (int i = 0; i < 6; i++) begin
         wr(8'ha8 + 8'(4 * i), 32'h00002000);
      end
      ch01IrqEn <= 2'h0;
      @(posedge clk_sys);
      cbusMatch01 <= 2'h1;
      @(posedge clk_sys);
      cbusMatch01 <= 2'h0;
      @(posedge clk_sys);
      #1 chk("irqGated", {31'h0, breakIrq}, 32'h0);
      @(posedge clk_sys);
      ch01IrqEn <= 2'h3;
      repeat (2) @(posedge clk_sys);
      #1 chk("irqAgain", {31'h0, breakIrq}, 32'h1);
      @(posedge clk_sys);
      rst_b <= 1'b0;
      @(posedge clk_sys);
      rst_b <= 1'b1;
      rdc(8'h30, 32'h0);
      rdc(8'hc0, 32'h0);
      close_out();
   end
endmodule : testbench
